// >>> common/lpd_pkg.sv
// shared constants and types of the led pwm dimmer
package lpd_pkg;

  // ****************************************************************
  // clocking and timing
  // ****************************************************************
  localparam int CLK_HZ      = 25_000_000;           // system clock rate
  localparam int PWM_CLK_HZ  = 2_000_000;            // modulator base rate
  localparam int PRESC_CYC   = CLK_HZ / PWM_CLK_HZ;  // system clocks per modulator tick
  localparam int PRESC_W     = 4;                    // prescaler width
  localparam int DUTY_W      = 6;                    // digital duty counter width
  localparam int CYC_PER_US  = CLK_HZ / 1_000_000;   // system clocks per microsecond
  localparam int FADE_T0_US  = 50_000;               // 50 ms step interval
  localparam int FADE_T1_US  = 25_000;               // 25 ms step interval
  localparam int FADE_T2_US  = 5_000;                // 5 ms step interval
  localparam int FADE_T3_US  = 2_500;                // 2.5 ms step interval
  localparam int FADE_CYC0   = FADE_T0_US * CYC_PER_US;
  localparam int FADE_CYC1   = FADE_T1_US * CYC_PER_US;
  localparam int FADE_CYC2   = FADE_T2_US * CYC_PER_US;
  localparam int FADE_CYC3   = FADE_T3_US * CYC_PER_US;
  localparam int FADE_W      = 21;                   // step interval timer width

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int CODE_W      = 8;                    // duty code and dac width
  localparam int NUM_SINKS   = 7;                    // sinks 1, 2, 6, 30, 31, 32, 33
  localparam logic [NUM_SINKS-1:0] ADDER_MASK = 7'h3F; // sink 33 has no adder
  localparam int ADDR_W      = 8;                    // apb address width
  localparam int DATA_W      = 32;                   // apb data width

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00; // fade mode and rate
  localparam logic [ADDR_W-1:0] ADDR_CODE   = 8'h04; // duty code
  localparam logic [ADDR_W-1:0] ADDR_STAT   = 8'h08; // modulator status
  localparam logic [ADDR_W-1:0] ADDR_SINK0  = 8'h10; // first per-sink register
  localparam int                SINK_SHIFT  = 2;     // one word per sink

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 1;                  // fade direction [2:1]
  localparam int CTRL_RATE_LSB = 3;                  // fade rate [5:3]
  localparam int SINK_SEL_LSB  = 0;                  // source select [1:0]
  localparam int SINK_OFS_EN   = 2;                  // offset enable
  localparam int SINK_INV_EN   = 3;                  // invert enable
  localparam int SINK_FS_LSB   = 8;                  // full scale level [15:8]
  localparam int SINK_OFS_LSB  = 16;                 // offset level [23:16]
  localparam int STAT_LEVEL    = 0;                  // modulated level
  localparam int STAT_SHIFT_LSB = 1;                 // analog divide shift [2:1]
  localparam int STAT_FADING   = 3;                  // fade still moving
  localparam int STAT_CNT_LSB  = 8;                  // duty counter [13:8]
  localparam logic [CODE_W-1:0] CODE_RST  = 8'h00;
  localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    LPD_DIM_NONE = 2'b00,   // code used as written
    LPD_DIM_UP   = 2'b01,   // logarithmic up fade
    LPD_DIM_DOWN = 2'b10,   // logarithmic down fade
    LPD_DIM_NA   = 2'b11    // undefined, no fade
  } lpd_dim_e;

  typedef enum logic [1:0] {
    LPD_SRC_OFF  = 2'b00,   // sink gated off
    LPD_SRC_ON   = 2'b01,   // sink gated on
    LPD_SRC_PWM  = 2'b10,   // sink gated by modulator
    LPD_SRC_PAT  = 2'b11    // sink gated by pattern input
  } lpd_src_e;

endpackage

// >>> rtl/lpd_sink_path.sv
// one sink's gating, analog scaling, inverter and offset adder
`timescale 1ns/10ps
module lpd_sink_path #(
  parameter bit HAS_ADDER = 1'b1                      // offset adder built for this sink
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            ce,
  input  wire logic [1:0]                      sink_source_select,
  input  wire logic [lpd_pkg::CODE_W-1:0]      sink_full_scale_level,
  input  wire logic                            sink_offset_enable,
  input  wire logic [lpd_pkg::CODE_W-1:0]      sink_offset_level,
  input  wire logic                            sink_invert_enable,
  input  wire logic                            pwm_level,
  input  wire logic [1:0]                      analog_shift,
  input  wire logic                            pattern_gate,
  output logic      [lpd_pkg::CODE_W-1:0]      dac_value,
  output logic                                 sink_on
);

  // ****************************************************************
  // output datapath
  // ****************************************************************
  logic [lpd_pkg::CODE_W-1:0] dac_reg, dac_next;   // value to current dac
  logic                       on_reg, on_next;     // sink gate
  logic                       gate;                // selected on/off source
  logic [lpd_pkg::CODE_W-1:0] scaled;              // full scale after analog divide
  logic [lpd_pkg::CODE_W-1:0] modres;              // modulator result

  // gate choice, analog divide, inversion and adder
  always_comb begin
    unique case (lpd_pkg::lpd_src_e'(sink_source_select))
      lpd_pkg::LPD_SRC_OFF: gate = 1'b0;
      lpd_pkg::LPD_SRC_ON:  gate = 1'b1;
      lpd_pkg::LPD_SRC_PWM: gate = pwm_level;       // [R1]
      lpd_pkg::LPD_SRC_PAT: gate = pattern_gate;
    endcase
    // analog divide only applies while the modulator gates the sink
    if (sink_source_select == lpd_pkg::LPD_SRC_PWM) begin
      scaled = sink_full_scale_level >> analog_shift; // [R3] [R4] [R5]
    end else begin
      scaled = sink_full_scale_level;
    end
    modres = gate ? scaled : lpd_pkg::CODE_ZERO;
    // inversion turns the result into offset - m - 1 after the adder
    if (sink_invert_enable) begin
      modres = ~modres;                             // [R14]
    end
    // adder works whatever the source select; wraps mod 256 by design
    if (HAS_ADDER && sink_offset_enable) begin
      dac_next = modres + sink_offset_level;        // [R12] [R16] [R17]
    end else begin
      dac_next = modres;
    end
    on_next = gate;
  end

  // register outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_reg <= lpd_pkg::CODE_ZERO;
      on_reg  <= 1'b0;
    end else if (ce) begin
      dac_reg <= dac_next;
      on_reg  <= on_next;
    end
  end

  assign dac_value = dac_reg;
  assign sink_on   = on_reg;

endmodule

// >>> rtl/lpd_top.sv
// shared led pwm dimmer: apb registers, modulator, fader and sink paths
//
// How it works
// R1: pwm-selected sinks share one modulated gate
// R2: modulator ticks 2 MHz, 6-bit counter
// R3: bit7 set: duty bits 7:2, full current
// R4: bit7 clear bit6 set: bits 6:1, half
// R5: bits 7,6 clear: bits 5:0, quarter current
// R6: direction 01 raises, 10 lowers the code
// R7: fading saturates at 255 and 0
// R8: code register always reads current code
// R9: one step per 50/25/5/2.5 ms interval
// R10: quarter down step subtracts max(1, code/4)
// R11: eighth down step subtracts max(1, code/8)
// R12: adder adds offset level to modulated value
// R13: software keeps full scale plus offset <=255
// R14: invert enable inverts modulator result logically
// R15: software keeps inverted result from going negative
// R16: adder works regardless of source select
// R17: only offset enable bit disables adder
// R18: rate even quarter, odd eighth, four intervals
// R19: code 00h always off, FFh always on
// R20: direction 00 none, 01 up, 10 down
// R21: up step adds max(1, fraction of code)
// R22: output high while counter below duty value
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module lpd_top #(
  parameter int NUM_SINKS = lpd_pkg::NUM_SINKS,       // number of sink paths
  parameter int FADE_CYC0 = lpd_pkg::FADE_CYC0,       // clocks per 50 ms
  parameter int FADE_CYC1 = lpd_pkg::FADE_CYC1,       // clocks per 25 ms
  parameter int FADE_CYC2 = lpd_pkg::FADE_CYC2,       // clocks per 5 ms
  parameter int FADE_CYC3 = lpd_pkg::FADE_CYC3        // clocks per 2.5 ms
) (
  input  wire logic                                  CLOCK,
  input  wire logic                                  RST,
  input  wire logic                                  CE,
  input  wire logic                                  PSEL,
  input  wire logic                                  PENABLE,
  input  wire logic                                  PWRITE,
  input  wire logic [lpd_pkg::ADDR_W-1:0]            PADDR,
  input  wire logic [lpd_pkg::DATA_W-1:0]            PWDATA,
  output logic      [lpd_pkg::DATA_W-1:0]            PRDATA,
  output logic                                       PREADY,
  output logic                                       PSLVERR,
  input  wire logic [NUM_SINKS-1:0]                  PATTERN_GATE,
  output logic      [NUM_SINKS*lpd_pkg::CODE_W-1:0]  SINK_DAC,
  output logic      [NUM_SINKS-1:0]                  SINK_ON
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int CW = lpd_pkg::CODE_W;               // code width
  localparam int DW = lpd_pkg::DATA_W;               // bus width

  // apb handshake
  logic          pready_reg, pready_next;            // answer strobe
  logic          pslverr_reg, pslverr_next;          // unmapped answer
  logic [DW-1:0] prdata_reg, prdata_next;            // read data
  logic          access;                             // access phase
  logic          commit;                             // edge the transfer completes
  logic          wr_commit;                          // write takes effect
  logic          mapped;                             // address decodes
  logic [DW-1:0] rd_mux;                             // read data source
  logic [lpd_pkg::ADDR_W-1:0] sink_off;              // offset into sink block
  logic [lpd_pkg::ADDR_W-1:0] sink_idx;              // addressed sink

  // control and code
  logic [1:0]    mode_reg, mode_next;                // fade direction
  logic [2:0]    rate_reg, rate_next;                // fade rate
  logic [CW-1:0] code_reg, code_next;                // duty code

  // per-sink settings
  logic [1:0]    sel_reg  [NUM_SINKS];               // source select
  logic [1:0]    sel_next [NUM_SINKS];
  logic [CW-1:0] fs_reg   [NUM_SINKS];               // full scale level
  logic [CW-1:0] fs_next  [NUM_SINKS];
  logic [CW-1:0] ofs_reg  [NUM_SINKS];               // offset level
  logic [CW-1:0] ofs_next [NUM_SINKS];
  logic          ofe_reg  [NUM_SINKS];               // offset enable
  logic          ofe_next [NUM_SINKS];
  logic          inv_reg  [NUM_SINKS];               // invert enable
  logic          inv_next [NUM_SINKS];

  // modulator
  logic [lpd_pkg::PRESC_W-1:0] presc_reg, presc_next; // 2 MHz tick divider
  logic [lpd_pkg::DUTY_W-1:0]  cnt_reg, cnt_next;     // duty counter
  logic                        lvl_reg, lvl_next;     // modulated level
  logic [1:0]                  shift_reg, shift_next; // analog divide
  logic [lpd_pkg::DUTY_W-1:0]  duty;                  // selected duty value
  logic                        tick;                  // modulator tick

  // fader
  logic [lpd_pkg::FADE_W-1:0]  ftmr_reg, ftmr_next;   // interval timer
  logic [lpd_pkg::FADE_W-1:0]  fade_last;             // timer end count
  logic                        fading;                // fade still moving
  logic [CW-1:0]               frac;                  // step size
  logic [CW:0]                 sum;                   // up step with carry

  // ****************************************************************
  // apb slave: one wait state, answer from flops
  // ****************************************************************
  assign access    = PSEL & PENABLE;
  assign commit    = access & pready_reg;
  assign wr_commit = commit & PWRITE & ~pslverr_reg;
  assign sink_off  = PADDR - lpd_pkg::ADDR_SINK0;
  assign sink_idx  = sink_off >> lpd_pkg::SINK_SHIFT;

  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    if (PADDR == lpd_pkg::ADDR_CTRL) begin
      rd_mux[lpd_pkg::CTRL_MODE_LSB +: 2] = mode_reg;
      rd_mux[lpd_pkg::CTRL_RATE_LSB +: 3] = rate_reg;
    end else if (PADDR == lpd_pkg::ADDR_CODE) begin
      rd_mux[CW-1:0] = code_reg;                     // [R8]
    end else if (PADDR == lpd_pkg::ADDR_STAT) begin
      rd_mux[lpd_pkg::STAT_LEVEL]               = lvl_reg;
      rd_mux[lpd_pkg::STAT_SHIFT_LSB +: 2]      = shift_reg;
      rd_mux[lpd_pkg::STAT_FADING]              = fading;
      rd_mux[lpd_pkg::STAT_CNT_LSB +: lpd_pkg::DUTY_W] = cnt_reg;
    end else if (PADDR >= lpd_pkg::ADDR_SINK0 && PADDR[1:0] == 2'h0
                 && sink_idx < lpd_pkg::ADDR_W'(NUM_SINKS)) begin
      for (int i = 0; i < NUM_SINKS; i++) begin
        if (sink_idx == lpd_pkg::ADDR_W'(i)) begin
          rd_mux[lpd_pkg::SINK_SEL_LSB +: 2] = sel_reg[i];
          rd_mux[lpd_pkg::SINK_OFS_EN]       = ofe_reg[i];
          rd_mux[lpd_pkg::SINK_INV_EN]       = inv_reg[i];
          rd_mux[lpd_pkg::SINK_FS_LSB +: CW] = fs_reg[i];
          rd_mux[lpd_pkg::SINK_OFS_LSB +: CW] = ofs_reg[i];
        end
      end
    end else begin
      mapped = 1'b0;                                 // unmapped: error answer
    end
  end

  // answer strobe rises in the second access cycle
  always_comb begin
    pready_next  = access & ~pready_reg;
    pslverr_next = access & ~pready_reg & ~mapped;
    prdata_next  = prdata_reg;
    if (access & ~pready_reg) begin
      prdata_next = (mapped & ~PWRITE) ? rd_mux : '0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else if (CE) begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ****************************************************************
  // per-sink settings
  // ****************************************************************
  // writes to the addressed sink word
  always_comb begin
    for (int i = 0; i < NUM_SINKS; i++) begin
      sel_next[i] = sel_reg[i];
      fs_next[i]  = fs_reg[i];
      ofs_next[i] = ofs_reg[i];
      ofe_next[i] = ofe_reg[i];
      inv_next[i] = inv_reg[i];
      if (wr_commit && PADDR >= lpd_pkg::ADDR_SINK0
          && sink_idx == lpd_pkg::ADDR_W'(i)) begin
        sel_next[i] = PWDATA[lpd_pkg::SINK_SEL_LSB +: 2];
        ofe_next[i] = PWDATA[lpd_pkg::SINK_OFS_EN];
        inv_next[i] = PWDATA[lpd_pkg::SINK_INV_EN];
        fs_next[i]  = PWDATA[lpd_pkg::SINK_FS_LSB +: CW];
        ofs_next[i] = PWDATA[lpd_pkg::SINK_OFS_LSB +: CW];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_SINKS; i++) begin
        sel_reg[i] <= lpd_pkg::LPD_SRC_OFF;
        fs_reg[i]  <= lpd_pkg::CODE_ZERO;
        ofs_reg[i] <= lpd_pkg::CODE_ZERO;
        ofe_reg[i] <= 1'b0;
        inv_reg[i] <= 1'b0;
      end
    end else if (CE) begin
      for (int i = 0; i < NUM_SINKS; i++) begin
        sel_reg[i] <= sel_next[i];
        fs_reg[i]  <= fs_next[i];
        ofs_reg[i] <= ofs_next[i];
        ofe_reg[i] <= ofe_next[i];
        inv_reg[i] <= inv_next[i];
      end
    end
  end

  // ****************************************************************
  // modulator
  // ****************************************************************
  assign tick = (presc_reg == lpd_pkg::PRESC_W'(lpd_pkg::PRESC_CYC - 1));

  // duty window and analog divide from the top code bits
  always_comb begin
    if (code_reg[7]) begin
      duty       = code_reg[7:2];                    // [R3]
      shift_next = 2'h0;
    end else if (code_reg[6]) begin
      duty       = code_reg[6:1];                    // [R4]
      shift_next = 2'h1;
    end else begin
      duty       = code_reg[5:0];                    // [R5]
      shift_next = 2'h2;
    end
    presc_next = tick ? '0 : presc_reg + 1'b1;       // [R2]
    cnt_next   = tick ? cnt_reg + 1'b1 : cnt_reg;    // [R2]
    if (code_reg == lpd_pkg::CODE_FULL) begin
      lvl_next = 1'b1;                               // [R19] [R22]
    end else begin
      lvl_next = (cnt_reg < duty);                   // [R19] [R22]
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      presc_reg <= '0;
      cnt_reg   <= '0;
      lvl_reg   <= 1'b0;
      shift_reg <= 2'h0;
    end else if (CE) begin
      presc_reg <= presc_next;
      cnt_reg   <= cnt_next;
      lvl_reg   <= lvl_next;
      shift_reg <= shift_next;
    end
  end

  // ****************************************************************
  // control, code and fader
  // ****************************************************************
  // interval by rate bits 2:1, fraction by rate bit 0
  always_comb begin
    unique case (rate_reg[2:1])                      // [R9] [R18]
      2'h0: fade_last = lpd_pkg::FADE_W'(FADE_CYC0 - 1);
      2'h1: fade_last = lpd_pkg::FADE_W'(FADE_CYC1 - 1);
      2'h2: fade_last = lpd_pkg::FADE_W'(FADE_CYC2 - 1);
      2'h3: fade_last = lpd_pkg::FADE_W'(FADE_CYC3 - 1);
    endcase
    frac = rate_reg[0] ? (code_reg >> 3) : (code_reg >> 2); // [R10] [R11] [R18]
    if (frac == lpd_pkg::CODE_ZERO) begin
      frac = CW'(1);                                 // least step of one
    end
    sum    = {1'b0, code_reg} + {1'b0, frac};
    fading = (mode_reg == lpd_pkg::LPD_DIM_UP && code_reg != lpd_pkg::CODE_FULL)
          || (mode_reg == lpd_pkg::LPD_DIM_DOWN && code_reg != lpd_pkg::CODE_ZERO);
  end

  // timer, step and register writes; a code write beats a fade step
  always_comb begin
    mode_next = mode_reg;
    rate_next = rate_reg;
    code_next = code_reg;
    ftmr_next = ftmr_reg;
    if (mode_reg == lpd_pkg::LPD_DIM_UP || mode_reg == lpd_pkg::LPD_DIM_DOWN) begin
      ftmr_next = (ftmr_reg >= fade_last) ? '0 : ftmr_reg + 1'b1;
      if (ftmr_reg >= fade_last) begin
        if (mode_reg == lpd_pkg::LPD_DIM_UP) begin
          code_next = sum[CW] ? lpd_pkg::CODE_FULL : sum[CW-1:0]; // [R6] [R7] [R21]
        end else begin
          code_next = (code_reg > frac) ? code_reg - frac : lpd_pkg::CODE_ZERO; // [R6] [R7]
        end
      end
    end else begin
      ftmr_next = '0;                                // [R20]
    end
    if (wr_commit && PADDR == lpd_pkg::ADDR_CTRL) begin
      mode_next = PWDATA[lpd_pkg::CTRL_MODE_LSB +: 2];
      rate_next = PWDATA[lpd_pkg::CTRL_RATE_LSB +: 3];
      ftmr_next = '0;                                // new setting restarts interval
    end
    if (wr_commit && PADDR == lpd_pkg::ADDR_CODE) begin
      code_next = PWDATA[CW-1:0];                    // start value of a fade
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode_reg <= lpd_pkg::LPD_DIM_NONE;
      rate_reg <= 3'h0;
      code_reg <= lpd_pkg::CODE_RST;
      ftmr_reg <= '0;
    end else if (CE) begin
      mode_reg <= mode_next;
      rate_reg <= rate_next;
      code_reg <= code_next;
      ftmr_reg <= ftmr_next;
    end
  end

  // ****************************************************************
  // sink paths
  // ****************************************************************
  for (genvar g = 0; g < NUM_SINKS; g++) begin : g_sink
    lpd_sink_path #(
      .HAS_ADDER (lpd_pkg::ADDER_MASK[g])
    ) u_path (
      .clk                   (CLOCK),
      .rst                   (RST),
      .ce                    (CE),
      .sink_source_select    (sel_reg[g]),
      .sink_full_scale_level (fs_reg[g]),
      .sink_offset_enable    (ofe_reg[g]),
      .sink_offset_level     (ofs_reg[g]),
      .sink_invert_enable    (inv_reg[g]),
      .pwm_level             (lvl_reg),
      .analog_shift          (shift_reg),
      .pattern_gate          (PATTERN_GATE[g]),
      .dac_value             (SINK_DAC[g*CW +: CW]),
      .sink_on               (SINK_ON[g])
    );
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;

endmodule

// >>> testbench/lpd_sink_model.sv
// sink current dac model counting sink 0 conduction
`timescale 1ns/10ps
module lpd_sink_model #(
  parameter int NUM_SINKS = 7
) (
  input wire logic                   clk,
  input wire logic [NUM_SINKS*8-1:0] sink_dac,
  input wire logic [NUM_SINKS-1:0]   sink_on,
  output int                         on_cnt
);
  // count clocks in which sink 0 draws current
  always @(posedge clk) begin
    on_cnt <= on_cnt + int'(sink_on[0] && |sink_dac[7:0]);
  end
endmodule

// >>> testbench/lpd_top_monitor.sv
// concurrent checks on the dimmer ports
`timescale 1ns/10ps
module lpd_top_monitor #(
  parameter int NUM_SINKS = 7
) (
  input wire logic                   CLOCK,
  input wire logic                   RST,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic                   PWRITE,
  input wire logic [7:0]             PADDR,
  input wire logic [31:0]            PWDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic [NUM_SINKS*8-1:0] SINK_DAC,
  input wire logic [NUM_SINKS-1:0]   SINK_ON
);
  // ****************
  // software shadow
  // ****************
  logic [31:0] s0;    // last sink 0 word
  logic [7:0]  code;  // last duty code
  logic [1:0]  dir;   // last fade direction
  logic        known; // code not fading
  logic [4:0]  quiet; // clocks since last write
  wire         wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire  [1:0]  sh = code[7] ? 2'h0 : code[6] ? 2'h1 : 2'h2;
  wire         calm = quiet > 5'h14;
  wire         pwm0 = known && s0[3:0] == 4'b0010 && calm;
  // follow completed writes
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {s0, code, dir, quiet} <= '0;
      known <= 1'b1;
    end else begin
      quiet <= wr ? 5'h0 : quiet + 5'(quiet != 5'h1F);
      if (wr && PADDR == lpd_pkg::ADDR_SINK0) s0 <= PWDATA;
      if (wr && PADDR == lpd_pkg::ADDR_CTRL) {dir, known} <= {PWDATA[2:1], known & ~^PWDATA[2:1]};
      if (wr && PADDR == lpd_pkg::ADDR_CODE) {code, known} <= {PWDATA[7:0], dir[1] == dir[0]};
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  AST_ACC_WAIT: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready late");
  AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  AST_ERR_QUAL: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("stray error");
  AST_SRC_OFF: assert property (calm && s0[1:0] == 2'b00 |-> !SINK_ON[0])
    else $error("on when off");
  AST_SRC_ON: assert property ((calm && s0[1:0] == 2'b01)[*2] |-> SINK_ON[0])
    else $error("off when on");
  AST_ZERO_OFF: assert property (pwm0 && code == 8'h00 |-> !SINK_ON[0])
    else $error("zero code on");
  AST_SCALE: assert property (pwm0 |-> SINK_DAC[7:0] == (SINK_ON[0] ? s0[15:8] >> sh : 8'h00))
    else $error("bad scaling");
  AST_OFS_ADD: assert property (calm && s0[3:0] == 4'b0100 |-> SINK_DAC[7:0] == s0[23:16])
    else $error("no offset");
  AST_INV: assert property (calm && s0[3:0] == 4'b1100 |-> SINK_DAC[7:0] == s0[23:16] - 8'h01)
    else $error("bad inversion");
endmodule
bind lpd_top lpd_top_monitor #(.NUM_SINKS(NUM_SINKS)) i_lpd_top_monitor (
  .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SINK_DAC(SINK_DAC), .SINK_ON(SINK_ON));

// >>> testbench/led_pwm_dimmer_tb.sv
// dimmer self-check bench
`timescale 1ns/10ps
module led_pwm_dimmer_tb;
  // ****************
  // signals
  // ****************
  localparam int FT [4] = '{80, 40, 16, 8}; // interval per rate pair
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [7:0]  PADDR, dv;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [6:0]  PATTERN_GATE, SINK_ON;
  logic [55:0] SINK_DAC;
  int          on_cnt, n0, g, fails = 0, tests_run = 0, cyc = 0;
  logic [7:0]  dc [5] = '{8'h80, 8'h40, 8'h20, 8'hFF, 8'h00};
  int          don [5] = '{1536, 1536, 1536, 3072, 0};
  logic [7:0]  dl [5] = '{8'h80, 8'h40, 8'h20, 8'h80, 8'h00};
  logic [31:0] sw [6] = '{32'h204004, 32'h204006, 32'h50200E, 32'h4001, 32'h4003, 32'h204004};
  logic [7:0]  se [6] = '{8'h20, 8'h60, 8'h2F, 8'h40, 8'h40, 8'h00};
  lpd_top #(.FADE_CYC0(80), .FADE_CYC1(40), .FADE_CYC2(16), .FADE_CYC3(8)) i_lpd_top (
    .CLOCK(CLOCK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PATTERN_GATE(PATTERN_GATE), .SINK_DAC(SINK_DAC), .SINK_ON(SINK_ON));
  lpd_sink_model i_lpd_sink_model (.clk(CLOCK), .sink_dac(SINK_DAC), .sink_on(SINK_ON),
    .on_cnt(on_cnt));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, wr, a, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    {rd, err} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'h0;
  endtask
  // fade k steps, then read the live code
  task automatic fade(input logic [7:0] c, input logic [1:0] dir, input int r, input int k);
    int s;
    apb(1, 8'h00, 0);
    apb(1, 8'h04, {24'h0, c});
    apb(1, 8'h00, {26'h0, r[2:0], dir, 1'b0});
    repeat (k * FT[r/2] + FT[r/2] / 2 - 3) @(posedge CLOCK);
    for (int i = 0; i < k; i++) begin
      s = c >> (2 + r % 2);
      if (s == 0) s = 1;
      if (dir == 2'b01) c = (c + s > 255) ? 8'hFF : 8'(c + s);
      if (dir == 2'b10) c = (c < s) ? 8'h00 : 8'(c - s);
    end
    apb(0, 8'h04, 0);
    chk("fade code", rd, {24'h0, c});
  endtask
  // clock and cycle ceiling
  initial begin
    CLOCK = 0;
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PATTERN_GATE} = {3'b100, 1'b0, 40'h0, 7'h7F};
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    apb(0, 8'h04, 0);
    chk("code reset", rd, 0);
    apb(0, 8'h0C, 0);
    chk("slave error", {31'h0, err}, 1);
    apb(1, 8'h04, 32'hFF);
    for (int i = 0; i < 6; i++) begin
      g = (i == 5) ? 6 : 0;
      apb(1, 8'h10 + 8'(4 * g), sw[i]);
      repeat (20) @(posedge CLOCK);
      chk("sink dac", {24'h0, SINK_DAC[8*g +: 8]}, {24'h0, se[i]});
      apb(0, 8'h10 + 8'(4 * g), 0);
      chk("sink read", rd, sw[i]);
    end
    apb(1, 8'h10, 32'h208002);
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h04, {24'h0, dc[i]});
      repeat (30) @(posedge CLOCK);
      n0 = on_cnt;
      dv = 8'h00;
      repeat (3072) @(posedge CLOCK) if (SINK_ON[0]) dv = SINK_DAC[7:0];
      chk("on clocks", on_cnt - n0, don[i]);
      chk("sink level", {24'h0, dv}, {24'h0, dl[i]});
    end
    for (int r = 0; r < 8; r++) fade(8'hFF, 2'b10, r, 3);
    fade(8'hFF, 2'b10, 0, 19);
    fade(8'hFF, 2'b10, 1, 37);
    fade(8'h03, 2'b10, 4, 6);
    fade(8'hF0, 2'b01, 1, 4);
    fade(8'h01, 2'b01, 2, 3);
    fade(8'h55, 2'b11, 6, 3);
    fade(8'h55, 2'b00, 6, 3);
    give_verdict();
  end
endmodule
